// ---- hdl/rhr_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rhr_pin_sync (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);

  logic meta_reg; // First stage, read only by the second
  logic sync2_reg; // Second stage
  logic sync3_reg; // Third stage
  logic level_reg; // Accepted level
  logic agree; // Second and third stages match

  // A change counts once two settled stages agree
  assign agree = (sync2_reg == sync3_reg);

  // Shift chain and accepted level
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= rhr_pkg::PIN_RESET_LEVEL;
      sync2_reg <= rhr_pkg::PIN_RESET_LEVEL;
      sync3_reg <= rhr_pkg::PIN_RESET_LEVEL;
      level_reg <= rhr_pkg::PIN_RESET_LEVEL;
    end else begin
      meta_reg <= pin_in;
      sync2_reg <= meta_reg;
      sync3_reg <= sync2_reg;
      if (agree) begin
        level_reg <= sync3_reg;
      end
    end
  end

  assign level_out = level_reg;

endmodule : rhr_pin_sync

// ---- hdl/rhr_pkg.sv ----
// Package with the constants and state codes of the reset, halt and run sequencer
// Function
// - Reset state on pin rise or bit rise
// - Both pins low hold the reset state
// - Powerup keeps reset for eight clocks
// - Reset exit runs call-zero then nop
// - Halt issues nops, host DMA continues
// - Powerup end, pin high: sequence then run
// - Powerup end, only tristate high: halt
// - Pin low or bit cleared halts run
// - Reset pin wins over control bit
// - Leaving halt passes reset and sequence
// - Pin pulse then low within ten halts
package rhr_pkg;

  // Cycles of reset state after powerup is detected
  localparam int unsigned PWRUP_CYC = 8;
  // Window after a pin rise in which a new low selects halt
  localparam int unsigned HALT_WINDOW_CYC = 10;
  // Width of the shared cycle counter
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] PWRUP_LAST = 4'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] WINDOW_LAST = 4'(HALT_WINDOW_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // Reset sequence call target and link register index
  localparam int unsigned CALL_ADDR_W = 16;
  localparam logic [CALL_ADDR_W-1:0] CALL_TARGET = 16'h0000;
  localparam logic [3:0] LINK_REG_INDEX = 4'he;

  // Pin synchroniser reset level (pins are idle high)
  localparam logic PIN_RESET_LEVEL = 1'b1;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_PWRUP = 6'h01, // Powerup or held reset state
    ST_RESET = 6'h02, // Reset state entered by an edge
    ST_CALL  = 6'h04, // Reset sequence, call slot
    ST_NOP   = 6'h08, // Reset sequence, nop slot
    ST_RUN   = 6'h10, // Fetch and execute
    ST_HALT  = 6'h20  // Internal nops only
  } rhr_state_t;

endpackage : rhr_pkg

// ---- hdl/rhr_sequencer.sv ----
// Reset, halt and run mode sequencer of the signal processor
`timescale 1ns/1ps
module rhr_sequencer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic reset_halt_n_in,
  input wire logic tristate_request_n_in,
  input wire logic run_halt_bit_in,
  output logic reset_state_out,
  output logic call_issue_out,
  output logic [rhr_pkg::CALL_ADDR_W-1:0] call_target_out,
  output logic [3:0] link_reg_sel_out,
  output logic nop_issue_out,
  output logic run_mode_out,
  output logic halt_mode_out,
  output logic dma_enable_out
);

  // Mode flow in brief
  // Powerup state: entered on asynchronous reset or both pins low
  // It counts a fixed number of cycles, then samples the reset pin
  // Pin high at that point ends in run, pin low ends in halt
  // Every exit from a reset state goes through the call slot
  // The call slot is followed by exactly one nop slot
  // Only after the nop slot does run or halt begin
  //
  // Edge-entered reset state
  // A pin release or a run bit rise starts it from run or halt
  // It lasts a fixed window so a quick second low can pick halt
  // Trade-off: every edge-entered reset costs the full window
  // Limitation: edges seen during a reset state or the sequence are dropped
  //
  // Priorities
  // Both pins low beats everything, including the sequence slots
  // The reset pin beats the run bit in both directions
  // A run bit rise counts only while the synchronised pin is high
  //
  // Timing seen from the pins
  // A pin change needs about five edges to reach the mode logic
  // Outputs are registered from the next state, so they match the state
  // Pulses shorter than about two cycles may never be seen at all
  //
  // Host DMA
  // Allowed in every state but the reset states
  // Halt keeps it running, since only instruction issue stops there

  // Synchronised pin levels
  logic reset_halt_n_sync; // Reset and halt request, active low
  logic tristate_request_n_sync; // Tristate request, active low

  // Edge history
  logic reset_halt_n_prev_reg; // Last cycle's synchronised reset pin
  logic run_halt_bit_prev_reg; // Last cycle's control bit

  // State and counter
  rhr_pkg::rhr_state_t state_reg;
  rhr_pkg::rhr_state_t state_next;
  logic [rhr_pkg::CNT_W-1:0] cnt_reg; // Cycles spent in the reset states
  logic [rhr_pkg::CNT_W-1:0] cnt_next;
  logic halt_target_reg; // Reset sequence will end in halt
  logic halt_target_next;

  // Registered outputs
  logic reset_state_reg;
  logic call_issue_reg;
  logic nop_issue_reg;
  logic run_mode_reg;
  logic halt_mode_reg;
  logic dma_enable_reg;

  // Decoded conditions
  logic pin_rise; // Reset pin released
  logic pin_low; // Reset pin asserted
  logic bit_rise; // Control bit written from 0 to 1
  logic bit_fall; // Control bit written from 1 to 0
  logic hold_reset; // Both pins asserted
  logic enter_reset; // Edge that starts a fresh reset state
  logic go_halt; // Run mode must stop
  logic pwrup_done; // Eight powerup cycles elapsed
  logic window_done; // Halt selection window elapsed
  logic in_pwrup;
  logic in_reset;
  logic in_call;
  logic in_nop;
  logic in_run;
  logic in_halt;

  // Pin synchronisers; mode logic sees only their filtered levels
  // The pins come from board logic with no relation to this clock
  // Reading them raw could split one change across two decisions
  // Both instances reset to the idle high level of the pins
  rhr_pin_sync u_sync_reset_halt (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .pin_in (reset_halt_n_in),
    .level_out (reset_halt_n_sync)
  );

  rhr_pin_sync u_sync_tristate (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .pin_in (tristate_request_n_in),
    .level_out (tristate_request_n_sync)
  );

  // State decode
  assign in_pwrup = (state_reg == rhr_pkg::ST_PWRUP);
  assign in_reset = (state_reg == rhr_pkg::ST_RESET);
  assign in_call = (state_reg == rhr_pkg::ST_CALL);
  assign in_nop = (state_reg == rhr_pkg::ST_NOP);
  assign in_run = (state_reg == rhr_pkg::ST_RUN);
  assign in_halt = (state_reg == rhr_pkg::ST_HALT);

  // Edge and level decode
  assign pin_rise = reset_halt_n_sync & ~reset_halt_n_prev_reg;
  assign pin_low = ~reset_halt_n_sync;
  assign bit_rise = run_halt_bit_in & ~run_halt_bit_prev_reg;
  assign bit_fall = ~run_halt_bit_in & run_halt_bit_prev_reg;
  assign hold_reset = ~tristate_request_n_sync & ~reset_halt_n_sync;
  // Bit rise only counts while the pin is high, so the pin wins
  assign enter_reset = pin_rise | (bit_rise & reset_halt_n_sync);
  // Pin low halts even if the bit still asks for run
  assign go_halt = pin_low | bit_fall;
  assign pwrup_done = (cnt_reg == rhr_pkg::PWRUP_LAST);
  assign window_done = (cnt_reg == rhr_pkg::WINDOW_LAST);

  // Next-state logic
  // The hold check sits outside the case so that it wins in any state
  // Counter and halt target travel with the state they belong to
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    halt_target_next = halt_target_reg;
    if (hold_reset) begin
      // Both pins low: held in reset, restarts like powerup
      state_next = rhr_pkg::ST_PWRUP;
      cnt_next = rhr_pkg::CNT_RESET;
      halt_target_next = 1'b0;
    end else begin
      unique case (state_reg)
        rhr_pkg::ST_PWRUP: begin
          // Count the powerup cycles, then sample the pins
          if (pwrup_done) begin
            state_next = rhr_pkg::ST_CALL;
            cnt_next = rhr_pkg::CNT_RESET;
            // Pin high runs whatever tristate is; else halt
            halt_target_next = ~reset_halt_n_sync;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        rhr_pkg::ST_RESET: begin
          // A new low inside the window selects halt
          if (pin_low) begin
            halt_target_next = 1'b1;
          end
          if (window_done) begin
            state_next = rhr_pkg::ST_CALL;
            cnt_next = rhr_pkg::CNT_RESET;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        rhr_pkg::ST_CALL: begin
          // Call slot of the reset sequence
          state_next = rhr_pkg::ST_NOP;
        end
        rhr_pkg::ST_NOP: begin
          // Sequence done; pin low at this point also forces halt
          if (halt_target_reg | pin_low) begin
            state_next = rhr_pkg::ST_HALT;
          end else begin
            state_next = rhr_pkg::ST_RUN;
          end
        end
        rhr_pkg::ST_RUN: begin
          if (enter_reset) begin
            state_next = rhr_pkg::ST_RESET;
            cnt_next = rhr_pkg::CNT_RESET;
            halt_target_next = 1'b0;
          end else if (go_halt) begin
            state_next = rhr_pkg::ST_HALT;
          end
        end
        rhr_pkg::ST_HALT: begin
          // Leave halt only through reset state and sequence
          if (enter_reset) begin
            state_next = rhr_pkg::ST_RESET;
            cnt_next = rhr_pkg::CNT_RESET;
            halt_target_next = 1'b0;
          end
        end
        default: begin
          // Illegal one-hot code recovers through powerup
          state_next = rhr_pkg::ST_PWRUP;
          cnt_next = rhr_pkg::CNT_RESET;
          halt_target_next = 1'b0;
        end
      endcase
    end
  end

  // Output decode from the next state, so outputs leave flops aligned with state
  logic reset_state_next;
  logic call_issue_next;
  logic nop_issue_next;
  logic run_mode_next;
  logic halt_mode_next;
  logic dma_enable_next;

  assign reset_state_next = (state_next == rhr_pkg::ST_PWRUP) |
                            (state_next == rhr_pkg::ST_RESET);
  assign call_issue_next = (state_next == rhr_pkg::ST_CALL);
  // Sequence nop and halt nops share one issue path
  assign nop_issue_next = (state_next == rhr_pkg::ST_NOP) |
                          (state_next == rhr_pkg::ST_HALT);
  assign run_mode_next = (state_next == rhr_pkg::ST_RUN);
  assign halt_mode_next = (state_next == rhr_pkg::ST_HALT);
  // Host DMA keeps going in halt; only the reset state stops it
  assign dma_enable_next = ~reset_state_next;

  // State, counter and edge history
  // Edge history resets to idle levels, so no false pin edge follows reset
  // Pin history starts high, run bit history starts low
  // A run bit already high after reset is ignored while in powerup
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= rhr_pkg::ST_PWRUP;
      cnt_reg <= rhr_pkg::CNT_RESET;
      halt_target_reg <= 1'b0;
      reset_halt_n_prev_reg <= rhr_pkg::PIN_RESET_LEVEL;
      run_halt_bit_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      halt_target_reg <= halt_target_next;
      reset_halt_n_prev_reg <= reset_halt_n_sync;
      run_halt_bit_prev_reg <= run_halt_bit_in;
    end
  end

  // Registered mode outputs
  // Reset values show the reset state with DMA stopped
  // Every output leaves a flop, so no decode glitch reaches the pins
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_state_reg <= 1'b1;
      call_issue_reg <= 1'b0;
      nop_issue_reg <= 1'b0;
      run_mode_reg <= 1'b0;
      halt_mode_reg <= 1'b0;
      dma_enable_reg <= 1'b0;
    end else begin
      reset_state_reg <= reset_state_next;
      call_issue_reg <= call_issue_next;
      nop_issue_reg <= nop_issue_next;
      run_mode_reg <= run_mode_next;
      halt_mode_reg <= halt_mode_next;
      dma_enable_reg <= dma_enable_next;
    end
  end

  // Call target is constant; link register index held only while the call slot is live
  logic [rhr_pkg::CALL_ADDR_W-1:0] call_target_reg;
  logic [3:0] link_reg_sel_reg;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      call_target_reg <= rhr_pkg::CALL_TARGET;
      link_reg_sel_reg <= 4'h0;
    end else begin
      call_target_reg <= rhr_pkg::CALL_TARGET;
      link_reg_sel_reg <= call_issue_next ? rhr_pkg::LINK_REG_INDEX : 4'h0;
    end
  end

  // Output pins driven straight from the registers above
  assign reset_state_out = reset_state_reg;
  assign call_issue_out = call_issue_reg;
  assign call_target_out = call_target_reg;
  assign link_reg_sel_out = link_reg_sel_reg;
  assign nop_issue_out = nop_issue_reg;
  assign run_mode_out = run_mode_reg;
  assign halt_mode_out = halt_mode_reg;
  assign dma_enable_out = dma_enable_reg;

endmodule : rhr_sequencer

// ---- verif/reset_halt_run_sequencer_tb.sv ----
// Self-checking bench of the reset, halt and run sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module reset_halt_run_sequencer_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0; // Powerup detect, low at start
  logic rh_want = 1'b1; // Wanted reset pin level
  logic zn_want = 1'b1; // Wanted tristate pin level
  logic run_bit = 1'b1; // Software run control
  wire logic rh_pin, zn_pin, rst_st, call_q, nop_q, run_q, halt_q, dma_q;
  wire logic [15:0] tgt;
  wire logic [3:0] lnk;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  // Free-running 250 MHz clock
  initial forever #2 clock_in = ~clock_in;

  rhr_pin_host i_rhr_pin_host (.clock_in(clock_in), .reset_halt_n_want_in(rh_want),
    .tristate_n_want_in(zn_want), .reset_halt_n_out(rh_pin), .tristate_request_n_out(zn_pin));
  rhr_sequencer i_rhr_sequencer (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .reset_halt_n_in(rh_pin), .tristate_request_n_in(zn_pin), .run_halt_bit_in(run_bit),
    .reset_state_out(rst_st), .call_issue_out(call_q), .call_target_out(tgt),
    .link_reg_sel_out(lnk), .nop_issue_out(nop_q), .run_mode_out(run_q),
    .halt_mode_out(halt_q), .dma_enable_out(dma_q));

  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Edges until a mode shows (0 call, 1 run, 2 halt, 3 reset), -1 if never
  task automatic wait_mode(input int sel, input int lim, output int k);
    k = -1;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clock_in);
      #1;
      if ((sel == 0 && call_q === 1'b1) || (sel == 1 && run_q === 1'b1) ||
          (sel == 2 && halt_q === 1'b1) || (sel == 3 && rst_st === 1'b1)) begin
        k = i;
        return;
      end
    end
  endtask : wait_mode

  // Powerup with given pin levels; ends on the release edge
  task automatic power_up(input logic rh, input logic zn);
    @(posedge clock_in);
    rh_want <= rh;
    zn_want <= zn;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
  endtask : power_up

  // Powerup with the reset pin high runs after the sequence
  task automatic t_pwr_run;
    power_up(1'b1, 1'b1);
    wait_mode(0, 12, n);
    `CHK(n, 8)
    wait_mode(1, 2, n);
    `CHK(n, 2)
    $display("test pwr_run done");
  endtask : t_pwr_run

  // Software bit halts, then restarts through a full reset
  task automatic t_bit;
    @(posedge clock_in) run_bit <= 1'b0;
    wait_mode(2, 3, n);
    `CHK(n > 0, 1'b1)
    @(posedge clock_in) run_bit <= 1'b1;
    wait_mode(3, 3, n);
    `CHK(n > 0, 1'b1)
    wait_mode(0, 12, n);
    `CHK(n, 10)
    wait_mode(1, 2, n);
    `CHK(n, 2)
    $display("test bit done");
  endtask : t_bit

  // Pin halts and outranks a bit rise; its release restarts
  task automatic t_pin;
    @(posedge clock_in) rh_want <= 1'b0;
    wait_mode(2, 8, n);
    `CHK(n > 0, 1'b1)
    @(posedge clock_in) run_bit <= 1'b0;
    @(posedge clock_in) run_bit <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK(halt_q, 1'b1)
    rh_want <= 1'b1;
    wait_mode(3, 8, n);
    `CHK(n > 0, 1'b1)
    wait_mode(1, 14, n);
    `CHK(n > 0, 1'b1)
    $display("test pin done");
  endtask : t_pin

  // Low, high, low again inside the window halts with no run
  task automatic t_pulse;
    @(posedge clock_in) rh_want <= 1'b0;
    repeat (8) @(posedge clock_in);
    rh_want <= 1'b1;
    wait_mode(3, 8, n);
    repeat (3) @(posedge clock_in);
    rh_want <= 1'b0;
    wait_mode(1, 20, n);
    `CHK(n, -1)
    `CHK(halt_q, 1'b1)
    $display("test pulse done");
  endtask : t_pulse

  // Second powerup with only the tristate pin high ends in halt
  task automatic t_pwr_halt;
    power_up(1'b0, 1'b1);
    wait_mode(0, 12, n);
    `CHK(n, 8)
    wait_mode(2, 2, n);
    `CHK(n, 2)
    `CHK({nop_q, dma_q}, 2'h3)
    $display("test pwr_halt done");
  endtask : t_pwr_halt

  // Both pins low hold reset; release behaves like powerup
  task automatic t_hold;
    power_up(1'b0, 1'b0);
    repeat (30) @(posedge clock_in);
    `CHK(rst_st, 1'b1)
    rh_want <= 1'b1;
    zn_want <= 1'b1;
    wait_mode(1, 25, n);
    `CHK(n >= 11 && n <= 18, 1'b1)
    $display("test hold done");
  endtask : t_hold

  // Main sequence; later tests start from the mode the last one left
  initial begin
    t_pwr_run;
    t_bit;
    t_pin;
    t_pulse;
    t_pwr_halt;
    t_hold;
    close_out;
  end

  // Watchdog far beyond the roughly 160 cycles the tests need
  initial begin
    #8000;
    error_cnt++;
    close_out;
  end
endmodule : reset_halt_run_sequencer_tb

// ---- verif/rhr_pin_host.sv ----
// Model of the system logic that drives the reset and tristate pins
`timescale 1ns/1ps
module rhr_pin_host (
  input wire logic clock_in,
  input wire logic reset_halt_n_want_in,
  input wire logic tristate_n_want_in,
  output logic reset_halt_n_out,
  output logic tristate_request_n_out
);
  // Pins start idle high, as the system holds them before any request
  initial begin
    reset_halt_n_out = 1'b1;
    tristate_request_n_out = 1'b1;
  end

  // Pins move only after an edge, like registered board logic
  // Plain always, since the initial block above also writes these pins
  always @(posedge clock_in) begin
    reset_halt_n_out <= reset_halt_n_want_in;
    tristate_request_n_out <= tristate_n_want_in;
  end
endmodule : rhr_pin_host

// ---- verif/rhr_sequencer_assertions.sv ----
// Port checker of the reset, halt and run sequencer
`timescale 1ns/1ps
module rhr_seq_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic reset_halt_n_in,
  input wire logic tristate_request_n_in,
  input wire logic run_halt_bit_in,
  input wire logic reset_state_out,
  input wire logic call_issue_out,
  input wire logic [15:0] call_target_out,
  input wire logic [3:0] link_reg_sel_out,
  input wire logic nop_issue_out,
  input wire logic run_mode_out,
  input wire logic halt_mode_out,
  input wire logic dma_enable_out
);
  logic [3:0] up_cnt_reg; // Edges since reset release

  // Saturating count, so it never wraps into the powerup span
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt_reg <= 4'h0;
    end else if (up_cnt_reg != 4'hf) begin
      up_cnt_reg <= up_cnt_reg + 4'h1;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  pwrup_hold_a: assert property (up_cnt_reg < 4'h8 |-> reset_state_out)
    else $error("reset state left early");
  pwrup_end_a: assert property (up_cnt_reg == 4'h8 && (reset_halt_n_in ||
    tristate_request_n_in) |-> call_issue_out) else $error("no call after powerup");
  call_slot_a: assert property (call_issue_out |-> link_reg_sel_out == 4'he &&
    call_target_out == 16'h0000 ##1 nop_issue_out && !call_issue_out)
    else $error("bad reset sequence");
  seq_entry_a: assert property ($fell(reset_state_out) |-> call_issue_out)
    else $error("reset left without call");
  halt_nop_a: assert property (halt_mode_out |-> nop_issue_out && dma_enable_out)
    else $error("halt without nop or dma");
  dma_gate_a: assert property (dma_enable_out == !reset_state_out)
    else $error("dma gate wrong");
  both_low_a: assert property ((!reset_halt_n_in && !tristate_request_n_in)[*8]
    |-> reset_state_out) else $error("both pins low, not reset");
  pin_low_a: assert property ((!reset_halt_n_in)[*7] |-> !run_mode_out)
    else $error("running with pin low");
  bit_halt_a: assert property (run_mode_out && $fell(run_halt_bit_in)
    |-> ##[1:2] halt_mode_out) else $error("bit clear did not halt");
  bit_exit_a: assert property (halt_mode_out && $rose(run_halt_bit_in) &&
    reset_halt_n_in |-> ##[1:2] reset_state_out) else $error("bit set did not reset");

  cover property (call_issue_out);
  cover property (run_mode_out ##1 halt_mode_out);
  cover property (halt_mode_out ##1 reset_state_out);
endmodule : rhr_seq_chk

bind rhr_sequencer rhr_seq_chk i_rhr_seq_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .reset_halt_n_in(reset_halt_n_in), .tristate_request_n_in(tristate_request_n_in),
  .run_halt_bit_in(run_halt_bit_in), .reset_state_out(reset_state_out),
  .call_issue_out(call_issue_out), .call_target_out(call_target_out),
  .link_reg_sel_out(link_reg_sel_out), .nop_issue_out(nop_issue_out),
  .run_mode_out(run_mode_out), .halt_mode_out(halt_mode_out),
  .dma_enable_out(dma_enable_out));
